/* rtl/signal_routing_matrix.sv */
// Protection signal routing and blocking matrix, top level.
// Assumes stage signals and control input 8 are synchronous to clk.
// Overview of operation
// - Input 8 blocks earth-fault low stage trip when its bit is set.
// - Input 8 blocks earth-fault high stage trip when its bit is set.
// - Bank enable plus input 8 selects the second setting bank.
// - Overcurrent latch bit holds the second trip signal until reset.
// - Earth-fault latch bit holds the second trip signal until reset.
// - Remote-reset bit plus input 8 clears latches and recorded values.
// - Routing bit sends overcurrent low start to signal one, default on.
// - Routing bit sends overcurrent low trip to open output, default on.
// - Routing bit sends overcurrent high trip to open output, default on.
// - Group two bit sends overcurrent high trip to signal three, default on.
// - Input 8 blocks overcurrent low stage trip when its bit is set.
//
// Strobed register access and the register offsets were left to the implementer.
module signal_routing_matrix
  import relay_matrix_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  input  wire logic                         ce,
  input  wire logic [relay_matrix_pkg::ADDR_W-1:0] addr,
  input  wire logic [relay_matrix_pkg::DATA_W-1:0] wdata,
  input  wire logic                         wr_en,
  input  wire logic                         rd_en,
  output logic [relay_matrix_pkg::DATA_W-1:0]      rdata,
  input  wire relay_matrix_pkg::stage_signals_t    stages,
  input  wire logic                         control_input8,
  output relay_matrix_pkg::relay_outputs_t  relays,
  output logic                              second_trip_signal,
  output logic                              second_bank_select,
  output logic                              clear_recorded
);
  import relay_matrix_pkg::*;

  // ==========================================================
  // Configuration registers
  logic [7:0] input_blocking_config;
  logic [7:0] output_routing_group_one;
  logic [7:0] output_routing_group_two;

  wire logic wr_blocking;
  wire logic wr_route_one;
  wire logic wr_route_two;
  wire logic wr_command;

  assign wr_blocking  = wr_en & (addr == OFS_BLOCKING);
  assign wr_route_one = wr_en & (addr == OFS_ROUTE_1);
  assign wr_route_two = wr_en & (addr == OFS_ROUTE_2);
  assign wr_command   = wr_en & (addr == OFS_COMMAND);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      input_blocking_config    <= RST_BLOCKING;
      output_routing_group_one <= RST_ROUTE_1;
      output_routing_group_two <= RST_ROUTE_2;
    end else if (ce) begin
      if (wr_blocking)  input_blocking_config    <= wdata;
      if (wr_route_one) output_routing_group_one <= wdata;
      if (wr_route_two) output_routing_group_two <= wdata;
    end
  end

  // ==========================================================
  // Trip blocking by control input 8
  stage_signals_t gated;
  wire logic      block_oc_low;
  wire logic      block_oc_high;
  wire logic      block_ef_low;
  wire logic      block_ef_high;

  assign block_oc_low  = control_input8 & input_blocking_config[BLK_OC_LOW];
  assign block_oc_high = control_input8 & input_blocking_config[BLK_OC_HIGH];
  assign block_ef_low  = control_input8 & input_blocking_config[BLK_EF_LOW];
  assign block_ef_high = control_input8 & input_blocking_config[BLK_EF_HIGH];

  assign gated.start        = stages.start;
  assign gated.trip.oc_low  = stages.trip.oc_low  & ~block_oc_low;
  assign gated.trip.oc_high = stages.trip.oc_high & ~block_oc_high;
  assign gated.trip.ef_low  = stages.trip.ef_low  & ~block_ef_low;
  assign gated.trip.ef_high = stages.trip.ef_high & ~block_ef_high;

  // ==========================================================
  // Routing onto the relays
  relay_outputs_t next_relays;

  route_or_matrix u_route (
    .route_one (output_routing_group_one),
    .route_two (output_routing_group_two),
    .stages    (gated),
    .relays    (next_relays)
  );

  // ==========================================================
  // Clearing of latches and recorded values
  wire logic remote_clear;
  wire logic latch_clear;
  logic      remote_clear_q;

  assign remote_clear = control_input8 & input_blocking_config[BLK_REMOTE_RST];
  assign latch_clear  = remote_clear | (wr_command & wdata[CMD_CLEAR]);

  // ==========================================================
  // Second trip signal with optional holding
  wire logic oc_trip;
  wire logic ef_trip;
  wire logic oc_held;
  wire logic ef_held;
  wire logic next_trip2;

  assign oc_trip = gated.trip.oc_low | gated.trip.oc_high;
  assign ef_trip = gated.trip.ef_low | gated.trip.ef_high;

  trip_hold_latch u_latch_oc (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .enable  (input_blocking_config[BLK_LATCH_OC]),
    .trip    (oc_trip),
    .clear   (latch_clear),
    .held    (oc_held)
  );

  trip_hold_latch u_latch_ef (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .enable  (input_blocking_config[BLK_LATCH_EF]),
    .trip    (ef_trip),
    .clear   (latch_clear),
    .held    (ef_held)
  );

  assign next_trip2 = oc_trip | ef_trip | oc_held | ef_held;

  // ==========================================================
  // Setting bank selection
  wire logic next_bank;

  assign next_bank = control_input8 & input_blocking_config[BLK_BANK_SEL];

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      relays             <= '0;
      second_trip_signal <= 1'b0;
      second_bank_select <= 1'b0;
      clear_recorded     <= 1'b0;
      remote_clear_q     <= 1'b0;
    end else if (ce) begin
      relays             <= next_relays;
      second_trip_signal <= next_trip2;
      second_bank_select <= next_bank;
      clear_recorded     <= (remote_clear & ~remote_clear_q) | (wr_command & wdata[CMD_CLEAR]);
      remote_clear_q     <= remote_clear;
    end
  end

  // ==========================================================
  // Register read port
  wire logic [7:0] status_word;
  logic [7:0]      next_rdata;

  assign status_word[7:6]         = 2'b00;
  assign status_word[ST_TRIP2]    = second_trip_signal;
  assign status_word[ST_OPEN]     = relays.open_cmd;
  assign status_word[ST_BANK]     = second_bank_select;
  assign status_word[ST_INPUT8]   = control_input8;
  assign status_word[ST_LATCH_EF] = ef_held;
  assign status_word[ST_LATCH_OC] = oc_held;

  always_comb begin
    case (addr)
      OFS_BLOCKING: next_rdata = input_blocking_config;
      OFS_ROUTE_1:  next_rdata = output_routing_group_one;
      OFS_ROUTE_2:  next_rdata = output_routing_group_two;
      OFS_STATUS:   next_rdata = status_word;
      default:      next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= rd_en ? next_rdata : 8'h00;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence oc_trip_seen_s;
    ce && stages.trip.oc_low && !block_oc_low && input_blocking_config[BLK_LATCH_OC];
  endsequence

  sequence no_trip_out_s;
    !second_trip_signal && !relays.open_cmd && !relays.sig_three && !relays.sig_four;
  endsequence

  sequence held_without_clear_s;
    ce && !latch_clear && !stages.trip.oc_low && !stages.trip.oc_high;
  endsequence

  oc_low_block_a: assert property (
    ce && control_input8 && input_blocking_config[BLK_OC_LOW] && stages.trip == 4'h1
    && !oc_held && !ef_held |=> no_trip_out_s)
    else $error("blocked overcurrent low trip reached an output");

  ef_low_block_a: assert property (
    ce && control_input8 && input_blocking_config[BLK_EF_LOW] && stages.trip == 4'h4
    && !oc_held && !ef_held |=> no_trip_out_s)
    else $error("blocked earth-fault low trip reached an output");

  ef_high_block_a: assert property (
    ce && control_input8 && input_blocking_config[BLK_EF_HIGH] && stages.trip == 4'h8
    && !oc_held && !ef_held |=> no_trip_out_s)
    else $error("blocked earth-fault high trip reached an output");

  bank_select_a: assert property (
    ce |=> second_bank_select == $past(control_input8 && input_blocking_config[BLK_BANK_SEL]))
    else $error("setting bank does not follow input 8");

  oc_latch_hold_a: assert property (
    oc_trip_seen_s ##1 (ce && input_blocking_config[BLK_LATCH_OC]) ##0 held_without_clear_s
    |=> second_trip_signal)
    else $error("overcurrent trip not held");

  ef_latch_hold_a: assert property (
    ce && ef_trip && input_blocking_config[BLK_LATCH_EF] ##1 ce && !latch_clear
    && input_blocking_config[BLK_LATCH_EF] |-> ef_held)
    else $error("earth-fault trip not held");

  remote_reset_a: assert property (
    ce && remote_clear && !oc_trip && !ef_trip |=> !oc_held && !ef_held)
    else $error("remote reset left a latch set");

  sig_one_route_a: assert property (
    ce && stages.start.oc_low && output_routing_group_one[R1_START_OC_LOW_SIG1]
    |=> relays.sig_one)
    else $error("overcurrent low start missing on signal one");

  open_route_a: assert property (
    ce && gated.trip.oc_low && output_routing_group_one[R1_TRIP_OC_LOW_OPEN]
    |=> relays.open_cmd)
    else $error("overcurrent low trip missing on open output");

  open_high_route_a: assert property (
    ce && gated.trip.oc_high && output_routing_group_one[R1_TRIP_OC_HIGH_OPEN]
    |=> relays.open_cmd)
    else $error("overcurrent high trip missing on open output");

  sig_three_route_a: assert property (
    ce && gated.trip.oc_high && output_routing_group_two[R2_TRIP_OC_HIGH_SIG3]
    |=> relays.sig_three)
    else $error("overcurrent high trip missing on signal three");

  or_quiet_a: assert property (
    ce && stages == '0 |=> relays == '0)
    else $error("output asserted with no source active");

  ce_freeze_a: assert property (
    !ce |=> $stable(relays) && $stable(second_trip_signal) && $stable(second_bank_select)
    && $stable(rdata))
    else $error("output moved while clock enable low");

  rd_quiet_a: assert property (
    ce && !rd_en |=> rdata == 8'h00)
    else $error("read data present without a read");

  oc_follow_a: assert property (
    ce && !input_blocking_config[BLK_LATCH_OC] |=> !oc_held)
    else $error("overcurrent latch held while disabled");

  ef_follow_a: assert property (
    ce && !input_blocking_config[BLK_LATCH_EF] |=> !ef_held)
    else $error("earth-fault latch held while disabled");

  cmd_clear_a: assert property (
    ce && wr_command && wdata[CMD_CLEAR] && !oc_trip && !ef_trip
    |=> !oc_held && !ef_held)
    else $error("clear command left a latch set");

  clear_pulse_a: assert property (
    ce && remote_clear && !remote_clear_q |=> clear_recorded)
    else $error("remote reset gave no clear pulse");

  clear_quiet_a: assert property (
    ce && !latch_clear |=> !clear_recorded)
    else $error("clear pulse without a clear request");

endmodule

/* rtl/relay_matrix_pkg.sv */
// Constants and types for the protection signal routing matrix.
// Assumes a single clock domain; imported by every matrix module except trip_hold_latch.
package relay_matrix_pkg;

  // ==========================================================
  // Register map
  localparam int         ADDR_W       = 4;
  localparam int         DATA_W       = 8;
  localparam logic [3:0] OFS_BLOCKING = 4'h0;
  localparam logic [3:0] OFS_ROUTE_1  = 4'h1;
  localparam logic [3:0] OFS_ROUTE_2  = 4'h2;
  localparam logic [3:0] OFS_STATUS   = 4'h3;
  localparam logic [3:0] OFS_COMMAND  = 4'h4;

  // ==========================================================
  // Blocking configuration fields
  localparam int BLK_OC_LOW    = 0;
  localparam int BLK_OC_HIGH   = 1;
  localparam int BLK_EF_LOW    = 2;
  localparam int BLK_EF_HIGH   = 3;
  localparam int BLK_BANK_SEL  = 4;
  localparam int BLK_LATCH_OC  = 5;
  localparam int BLK_LATCH_EF  = 6;
  localparam int BLK_REMOTE_RST = 7;

  // ==========================================================
  // Routing fields
  localparam int R1_START_OC_LOW_SIG1 = 0;
  localparam int R1_TRIP_OC_LOW_OPEN  = 1;
  localparam int R1_TRIP_OC_HIGH_OPEN = 3;
  localparam int R2_TRIP_OC_HIGH_SIG3 = 0;

  // ==========================================================
  // Status and command fields
  localparam int ST_LATCH_OC  = 0;
  localparam int ST_LATCH_EF  = 1;
  localparam int ST_INPUT8    = 2;
  localparam int ST_BANK      = 3;
  localparam int ST_OPEN      = 4;
  localparam int ST_TRIP2     = 5;
  localparam int CMD_CLEAR    = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_BLOCKING = 8'h00;
  localparam logic [7:0] RST_ROUTE_1  = 8'hAB;
  localparam logic [7:0] RST_ROUTE_2  = 8'h21;

  // ==========================================================
  // Signal bundles
  typedef struct packed {
    logic ef_high;
    logic ef_low;
    logic oc_high;
    logic oc_low;
  } stage_set_t;

  typedef struct packed {
    stage_set_t start;
    stage_set_t trip;
  } stage_signals_t;

  typedef struct packed {
    logic open_cmd;
    logic sig_one;
    logic sig_three;
    logic sig_four;
  } relay_outputs_t;

endpackage

/* rtl/route_or_matrix.sv */
// Routing matrix: OR of routed stage signals onto each output.
// Assumes trips arrive already blocked; purely combinational.
module route_or_matrix
  import relay_matrix_pkg::*;
(
  input  wire logic [7:0]     route_one,
  input  wire logic [7:0]     route_two,
  input  wire stage_signals_t stages,
  output relay_outputs_t      relays
);

  // ==========================================================
  // Source vectors, one per routing bit
  wire logic [7:0] src_one;
  wire logic [7:0] src_two;
  wire logic [3:0] sig1_terms;
  wire logic [3:0] open_terms;
  wire logic [3:0] sig3_terms;
  wire logic [3:0] sig4_terms;

  assign src_one = {stages.trip.ef_high, stages.start.ef_high,
                    stages.trip.ef_low,  stages.start.ef_low,
                    stages.trip.oc_high, stages.start.oc_high,
                    stages.trip.oc_low,  stages.start.oc_low};
  assign src_two = {stages.trip.oc_low,  stages.trip.oc_low,
                    stages.trip.ef_high, stages.trip.ef_high,
                    stages.trip.ef_low,  stages.trip.ef_low,
                    stages.trip.oc_high, stages.trip.oc_high};

  // ==========================================================
  // Gating per routing pair
  // routing bit gates
  for (genvar i = 0; i < 4; i++) begin : g_pair
    assign sig1_terms[i] = route_one[2*i]   & src_one[2*i];
    assign open_terms[i] = route_one[2*i+1] & src_one[2*i+1];
    assign sig3_terms[i] = route_two[2*i]   & src_two[2*i];
    assign sig4_terms[i] = route_two[2*i+1] & src_two[2*i+1];
  end

  assign relays.open_cmd  = |open_terms;
  assign relays.sig_one   = |sig1_terms;
  assign relays.sig_three = |sig3_terms;
  assign relays.sig_four  = |sig4_terms;

endmodule

/* rtl/trip_hold_latch.sv */
// Holding latch for one class of trip on the second trip signal.
// Assumes trip and clear are synchronous to clk.
module trip_hold_latch (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic ce,
  input  wire logic enable,
  input  wire logic trip,
  input  wire logic clear,
  output logic      held
);

  // ==========================================================
  // Latch state, set wins over clear
  wire logic next_held;

  assign next_held = enable & (trip | (held & ~clear));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      held <= 1'b0;
    end else if (ce) begin
      held <= next_held;
    end
  end

endmodule

/* testbench/stage_source.sv */
// Partner model: protection stage comparators feeding the matrix.
// Assumes the bench commands new stage levels with a load strobe.
module stage_source (
  input  wire logic                             clk,
  input  wire logic                             reset_n,
  input  wire logic                             load,
  input  wire relay_matrix_pkg::stage_signals_t value,
  output relay_matrix_pkg::stage_signals_t      stages
);
  timeunit 1ns;
  timeprecision 1ps;
  import relay_matrix_pkg::*;

  // ==========================================================
  // Stage levels, registered like real comparator outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stages <= '0;
    end else if (load) begin
      stages <= value;
    end
  end
endmodule

/* testbench/signal_routing_matrix_tb.sv */
// Self-checking bench for the routing and blocking matrix.
// Assumes the stage_source partner and the matrix package.
module signal_routing_matrix_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import relay_matrix_pkg::*;

  typedef struct {int cyc; int kind; logic [7:0] val;} note_t;

  logic                 clk;
  logic                 reset_n;
  logic                 ce;
  logic                 wr_en;
  logic                 rd_en;
  logic                 control_input8;
  logic                 load;
  logic [ADDR_W-1:0]    addr;
  logic [DATA_W-1:0]    wdata;
  logic [DATA_W-1:0]    rdata;
  stage_signals_t       stages;
  stage_signals_t       stage_cmd;
  relay_outputs_t       relays;
  logic                 second_trip_signal;
  logic                 second_bank_select;
  logic                 clear_recorded;
  logic [31:0]          seed;
  logic [7:0]           blk;
  logic [7:0]           r1;
  logic [7:0]           r2;
  int                   cyc = 0;
  int                   error_cnt = 0;
  int                   checks_done = 0;
  note_t                q[$];

  stage_source stage_source_i (.clk(clk), .reset_n(reset_n), .load(load), .value(stage_cmd), .stages(stages));

  signal_routing_matrix signal_routing_matrix_i (
    .clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .stages(stages), .control_input8(control_input8), .relays(relays),
    .second_trip_signal(second_trip_signal), .second_bank_select(second_bank_select),
    .clear_recorded(clear_recorded));

  // ==========================================================
  // Clock and timeout
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 2000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  function automatic logic [5:0] ref_out(stage_signals_t s, logic in8, logic held);
    logic [3:0]     t;
    relay_outputs_t r;
    t = s.trip & ~(blk[3:0] & {4{in8}});
    r.open_cmd = |(t & {r1[7], r1[5], r1[3], r1[1]});
    r.sig_one = |(s.start & {r1[6], r1[4], r1[2], r1[0]});
    r.sig_three = |(t & {r2[4], r2[2], r2[0], r2[6]});
    r.sig_four = |(t & {r2[5], r2[3], r2[1], r2[7]});
    return {r, (|t) | held, blk[4] & in8};
  endfunction

  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic note(int dly, int kind, logic [7:0] v);
    q.push_back('{cyc + dly, kind, v});
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    if (a == OFS_COMMAND) note(2, 2, 8'h01);
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    note(2, 1, e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  task automatic cfg(logic [7:0] b, logic [7:0] a1, logic [7:0] a2);
    blk = b;
    r1 = a1;
    r2 = a2;
    wr(OFS_BLOCKING, b);
    wr(OFS_ROUTE_1, a1);
    wr(OFS_ROUTE_2, a2);
  endtask

  task automatic drive(stage_signals_t s, logic in8);
    @(posedge clk);
    stage_cmd <= s;
    control_input8 <= in8;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
  endtask

  task automatic settle(logic [5:0] e);
    repeat (5) @(posedge clk);
    note(1, 0, {2'b00, e});
  endtask

  task automatic print_verdict();
    if (q.size() > 0) error_cnt++;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Monitor: compare each note in its cycle
  always @(negedge clk) begin
    while (q.size() > 0 && q[0].cyc <= cyc) begin
      case (q[0].kind)
        0: check("outputs", {2'b00, relays, second_trip_signal, second_bank_select}, q[0].val);
        1: check("rdata", rdata, q[0].val);
        default: check("clear", {7'h00, clear_recorded}, q[0].val);
      endcase
      void'(q.pop_front());
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    addr = '0;
    wdata = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    control_input8 = 1'b0;
    load = 1'b0;
    stage_cmd = '0;
    seed = 32'hD7A7;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rd(OFS_BLOCKING, 8'h00);
    rd(OFS_ROUTE_1, RST_ROUTE_1);
    rd(OFS_ROUTE_2, RST_ROUTE_2);
    rd(4'hF, 8'h00);
    wr(OFS_STATUS, 8'hFF);
    rd(OFS_STATUS, 8'h00);
    blk = RST_BLOCKING;
    r1 = RST_ROUTE_1;
    r2 = RST_ROUTE_2;
    for (int i = 0; i < 8; i++) begin
      drive(stage_signals_t'(8'h01 << i), 1'b0);
      settle(ref_out(stage_signals_t'(8'h01 << i), 1'b0, 1'b0));
    end
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      cfg(seed[7:0] & 8'h9F, seed[15:8], seed[23:16]);
      seed = xs(seed);
      drive(stage_signals_t'(seed[7:0]), seed[8]);
      settle(ref_out(stage_signals_t'(seed[7:0]), seed[8], 1'b0));
    end
    cfg(8'h0D, RST_ROUTE_1, RST_ROUTE_2);
    for (int i = 0; i < 4; i++) begin
      drive(stage_signals_t'(8'h01 << i), 1'b1);
      settle(ref_out(stage_signals_t'(8'h01 << i), 1'b1, 1'b0));
    end
    cfg(8'h20, RST_ROUTE_1, RST_ROUTE_2);
    drive(stage_signals_t'(8'h01), 1'b0);
    settle(ref_out(stage_signals_t'(8'h01), 1'b0, 1'b1));
    drive('0, 1'b0);
    settle(ref_out('0, 1'b0, 1'b1));
    wr(OFS_COMMAND, 8'h01);
    settle(ref_out('0, 1'b0, 1'b0));
    cfg(8'hC0, RST_ROUTE_1, RST_ROUTE_2);
    drive(stage_signals_t'(8'h04), 1'b0);
    drive('0, 1'b0);
    settle(ref_out('0, 1'b0, 1'b1));
    @(posedge clk);
    control_input8 <= 1'b1;
    note(2, 2, 8'h01);
    settle(ref_out('0, 1'b1, 1'b0));
    @(posedge clk);
    control_input8 <= 1'b0;
    ce <= 1'b0;
    drive(stage_signals_t'(8'h02), 1'b0);
    settle(ref_out('0, 1'b0, 1'b0));
    ce <= 1'b1;
    settle(ref_out(stage_signals_t'(8'h02), 1'b0, 1'b0));
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule
